// ### core/hbs_host_port.sv
// host bus cycle timing for a parallel port and timer peripheral
// assumes a bus master driving csN, rw, regSelect and dataIn asynchronously to clk, handshake
// inputs asserted low, and an outside wire resolver for the three-state and open-drain pins
//
// How it works
// R01: port interrupt changes three clocks after a synchronized chip select that starts a cycle while no interrupt countdown is running.
// R02: port interrupt changes 2.5 to 3.5 clocks after a synchronized handshake input.
// R03: internal work of a cycle ends within three clocks after the acknowledge.
// R04: chip select arriving while still busy defers the cycle and its acknowledge.
// R05: acknowledge may come one clock late when chip select misses its sample.
// R06: the master holds chip select low for at least one clock.
// R07: handshakes and chip select count as synchronized once seen on a sampling edge.
// R08: a late handshake assertion may be recognized one clock later.
// R09: handshake coinciding with a bus access may take the longest response time.
// R10: timer count input is sampled on clk; too short periods may be lost.
// R11: timer count input is slower than clk unless from the same source.
// R12: pulsed output handshake ends early when its input handshake asserts.
// R13: write data, register select and direction are captured as chip select asserts.
// R14: chip select and handshakes pass clocked synchronizers before any logic uses them.
`timescale 1ns/10ps
module hbs_host_port #(
    parameter int PULSE_CLKS = hbs_pkg::HS_PULSE_CLKS,
    parameter int TIMER_WIDTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic csN,
    input wire logic rw,
    input wire logic [4:0] regSelect,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic transferAckN,
    output logic transferAckOe,
    output logic portIrqN,
    output logic portIrqOe,
    input wire logic hsInAN,
    input wire logic hsInBN,
    output logic hsOutAN,
    output logic hsOutBN,
    input wire logic pulsedMode,
    input wire logic timerCountIn,
    output logic [TIMER_WIDTH-1:0] timerCount,
    output logic [7:0] portDataA,
    output logic [7:0] portDataB,
    output hbs_pkg::hbs_write_t hostWrite
);

    localparam logic [1:0] IRQ_CS_LOAD = 2'(hbs_pkg::IRQ_CS_DELAY_CLKS - 1);
    localparam logic [1:0] IRQ_HS_LOAD = 2'(hbs_pkg::IRQ_HS_DELAY_CLKS - 1);
    localparam logic [1:0] OPS_LOAD = 2'(hbs_pkg::OPS_DONE_CLKS);
    localparam logic [7:0] PULSE_LOAD = 8'(PULSE_CLKS);

    typedef struct packed {
        hbs_pkg::hbs_bus_state_t bus;
        logic [1:0] opsLeft;
        logic pendCs;
        logic csPrev;
        logic [4:0] regSel;
        logic rw;
        logic [7:0] wrData;
        logic [7:0] dataOut;
        logic dataOe;
        hbs_pkg::hbs_pin_t ack;
        hbs_pkg::hbs_pin_t irq;
        logic [1:0] irqCnt;
        logic [1:0] hsPrev;
        logic [1:0] irqFlag;
        logic [1:0] irqEn;
        logic [1:0] hsOutN;
        logic [1:0][7:0] pulseCnt;
        logic [1:0][7:0] portData;
        logic tinPrev;
        logic [TIMER_WIDTH-1:0] timerCount;
        hbs_pkg::hbs_write_t wr;
    } hbs_port_state_t;

    hbs_port_state_t st;
    hbs_port_state_t next_st;

    hbs_pkg::hbs_bus_in_t busPins;
    hbs_pkg::hbs_bus_in_t busSync;
    logic [1:0] hsSyncN;
    logic tinSync;

    assign busPins = '{csN: csN, rw: rw, regSelect: regSelect, data: dataIn};

    // bus lines are synchronised as one group so the captured fields match the chip select sample
    hbs_sync #(
        .WIDTH($bits(hbs_pkg::hbs_bus_in_t)),
        .RESET_VALUE({1'b1, 1'b1, 5'h00, 8'h00})
    ) u_bus_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(busPins),
        .dout(busSync)
    ); // R14

    hbs_sync #(
        .WIDTH(2),
        .RESET_VALUE(2'h3)
    ) u_hs_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({hsInBN, hsInAN}),
        .dout(hsSyncN)
    ); // R14

    hbs_sync #(
        .WIDTH(1),
        .RESET_VALUE(1'b0)
    ) u_tin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(timerCountIn),
        .dout(tinSync)
    ); // R10

    always_comb
    begin
        logic csEdge;
        logic csTake;
        logic [1:0] hsEdge;
        logic [1:0] clearMask;
        logic [1:0] writeHit;

        next_st = st;
        csEdge = 1'b0;
        csTake = 1'b0;
        hsEdge = 2'h0;
        clearMask = 2'h0;
        writeHit = 2'h0;

        next_st.wr.strobe = 1'b0;
        next_st.csPrev = busSync.csN;

        // a new falling chip select, seen on its sampling edge
        csEdge = st.csPrev & ~busSync.csN; // R07

        // internal work of the last cycle drains down to zero
        if (st.opsLeft != 2'h0)
        begin
            next_st.opsLeft = st.opsLeft - 2'h1; // R03
        end

        // a chip select that lands while still busy waits here rather than being lost
        if (csEdge && (st.opsLeft != 2'h0 || st.bus != hbs_pkg::HBS_IDLE))
        begin
            next_st.pendCs = 1'b1; // R04
        end

        unique case (st.bus)
            hbs_pkg::HBS_IDLE:
            begin
                // a deferred cycle only starts if chip select is still low when work is done
                csTake = (csEdge || (st.pendCs && !busSync.csN)) && st.opsLeft == 2'h0; // R04
                if (st.pendCs && busSync.csN)
                begin
                    next_st.pendCs = 1'b0;
                end
                if (csTake)
                begin
                    next_st.pendCs = 1'b0;
                    next_st.regSel = busSync.regSelect; // R13
                    next_st.rw = busSync.rw; // R13
                    next_st.wrData = busSync.data; // R13
                    next_st.irqCnt = IRQ_CS_LOAD; // R01
                    next_st.bus = hbs_pkg::HBS_ACK;
                end
            end
            hbs_pkg::HBS_ACK:
            begin
                // one clock after capture, which sits inside the late-by-one allowance
                next_st.ack = '{level: 1'b0, oe: 1'b1}; // R05
                next_st.opsLeft = OPS_LOAD; // R03
                if (st.rw)
                begin
                    next_st.dataOe = 1'b1;
                    unique case (st.regSel)
                        hbs_pkg::REG_DATA_A: next_st.dataOut = st.portData[0];
                        hbs_pkg::REG_DATA_B: next_st.dataOut = st.portData[1];
                        hbs_pkg::REG_STATUS: next_st.dataOut = {6'h00, st.irqFlag};
                        hbs_pkg::REG_ENABLE: next_st.dataOut = {6'h00, st.irqEn};
                        default: next_st.dataOut = 8'h00;
                    endcase
                end
                else
                begin
                    next_st.wr = '{strobe: 1'b1, regSelect: st.regSel, data: st.wrData};
                    unique case (st.regSel)
                        hbs_pkg::REG_DATA_A:
                        begin
                            next_st.portData[0] = st.wrData;
                            writeHit[0] = 1'b1;
                        end
                        hbs_pkg::REG_DATA_B:
                        begin
                            next_st.portData[1] = st.wrData;
                            writeHit[1] = 1'b1;
                        end
                        hbs_pkg::REG_STATUS: clearMask = st.wrData[1:0];
                        hbs_pkg::REG_ENABLE: next_st.irqEn = st.wrData[1:0];
                        default: clearMask = 2'h0;
                    endcase
                end
                next_st.bus = hbs_pkg::HBS_HOLD;
            end
            hbs_pkg::HBS_HOLD:
            begin
                // acknowledge is driven high for one clock before it floats
                if (busSync.csN)
                begin
                    next_st.ack = '{level: 1'b1, oe: 1'b1};
                    next_st.dataOe = 1'b0;
                    next_st.bus = hbs_pkg::HBS_RELEASE;
                end
            end
            hbs_pkg::HBS_RELEASE:
            begin
                next_st.ack = '{level: 1'b1, oe: 1'b0};
                next_st.bus = hbs_pkg::HBS_IDLE;
            end
        endcase

        // handshake assertions count once seen; a late one simply shows a clock later
        hsEdge = st.hsPrev & ~hsSyncN; // R07 R08
        next_st.hsPrev = hsSyncN;

        // the set wins over a clear written in the same cycle
        next_st.irqFlag = (st.irqFlag & ~clearMask) | hsEdge;

        // a handshake sharing the cycle with a bus access just reuses the same countdown
        if (hsEdge != 2'h0 && !csTake)
        begin
            next_st.irqCnt = IRQ_HS_LOAD; // R02 R09
        end

        if (st.irqCnt != 2'h0)
        begin
            next_st.irqCnt = st.irqCnt - 2'h1;
            if (st.irqCnt == 2'h1 && !(csTake || hsEdge != 2'h0))
            begin
                // open drain: pull low while a flag is enabled, otherwise float
                next_st.irq = '{level: 1'b0, oe: |(st.irqFlag & st.irqEn)}; // R01 R02
            end
        end

        // output handshakes: interlocked by default, pulsed when selected
        for (int i = 0; i < 2; i++)
        begin
            if (writeHit[i])
            begin
                next_st.hsOutN[i] = 1'b0;
                next_st.pulseCnt[i] = PULSE_LOAD;
            end
            else if (!st.hsOutN[i])
            begin
                if (st.pulseCnt[i] != 8'h00)
                begin
                    next_st.pulseCnt[i] = st.pulseCnt[i] - 8'h01;
                end
                if (!hsSyncN[i])
                begin
                    // early input assertion cuts the pulse short
                    next_st.hsOutN[i] = 1'b1; // R12
                    next_st.pulseCnt[i] = 8'h00;
                end
                else if (pulsedMode && st.pulseCnt[i] <= 8'h01)
                begin
                    next_st.hsOutN[i] = 1'b1;
                end
            end
        end

        // sampled on clk, so a timer input period shorter than clk can drop a count
        next_st.tinPrev = tinSync;
        if (tinSync && !st.tinPrev)
        begin
            next_st.timerCount = st.timerCount + TIMER_WIDTH'(1); // R10
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st.bus <= hbs_pkg::HBS_IDLE;
            st.opsLeft <= 2'h0;
            st.pendCs <= 1'b0;
            st.csPrev <= 1'b1;
            st.regSel <= 5'h00;
            st.rw <= 1'b1;
            st.wrData <= hbs_pkg::DATA_RESET;
            st.dataOut <= hbs_pkg::DATA_RESET;
            st.dataOe <= 1'b0;
            st.ack <= '{level: 1'b1, oe: 1'b0};
            st.irq <= '{level: 1'b0, oe: 1'b0};
            st.irqCnt <= 2'h0;
            st.hsPrev <= 2'h3;
            st.irqFlag <= 2'h0;
            st.irqEn <= hbs_pkg::ENABLE_RESET;
            st.hsOutN <= 2'h3;
            st.pulseCnt <= '0;
            st.portData <= '0;
            st.tinPrev <= 1'b0;
            st.timerCount <= '0;
            st.wr <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign dataOut = st.dataOut;
    assign dataOe = st.dataOe;
    assign transferAckN = st.ack.level;
    assign transferAckOe = st.ack.oe;
    assign portIrqN = st.irq.level;
    assign portIrqOe = st.irq.oe;
    assign hsOutAN = st.hsOutN[0];
    assign hsOutBN = st.hsOutN[1];
    assign timerCount = st.timerCount;
    assign portDataA = st.portData[0];
    assign portDataB = st.portData[1];
    assign hostWrite = st.wr;

endmodule : hbs_host_port

// ### core/hbs_pkg.sv
// shared constants and carrier types for the host bus cycle timing block
// assumes one clock (clk) and a synchronous active-high reset; all pins are asynchronous to clk
package hbs_pkg;

    // internal register indices seen through reg_select
    localparam logic [4:0] REG_DATA_A = 5'h00;
    localparam logic [4:0] REG_DATA_B = 5'h01;
    localparam logic [4:0] REG_STATUS = 5'h02;
    localparam logic [4:0] REG_ENABLE = 5'h03;

    // status and enable field positions
    localparam int FLAG_A_POS = 0;
    localparam int FLAG_B_POS = 1;

    // reset values
    localparam logic [1:0] ENABLE_RESET = 2'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // timing counts, in clock periods
    localparam int IRQ_CS_DELAY_CLKS = 3;
    localparam int IRQ_HS_DELAY_CLKS = 3;
    localparam int OPS_DONE_CLKS = 3;
    localparam int HS_PULSE_CLKS = 4;

    typedef enum logic [3:0] {
        HBS_IDLE = 4'b0001,
        HBS_ACK = 4'b0010,
        HBS_HOLD = 4'b0100,
        HBS_RELEASE = 4'b1000
    } hbs_bus_state_t;

    // bus lines as sampled from the host
    typedef struct packed {
        logic csN;
        logic rw;
        logic [4:0] regSelect;
        logic [7:0] data;
    } hbs_bus_in_t;

    // one completed host write as seen by the user side
    typedef struct packed {
        logic strobe;
        logic [4:0] regSelect;
        logic [7:0] data;
    } hbs_write_t;

    // open-drain or three-state pin as driven by the device
    typedef struct packed {
        logic level;
        logic oe;
    } hbs_pin_t;

endpackage : hbs_pkg

// ### core/hbs_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk; only the second stage may be read
`timescale 1ns/10ps
module hbs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } hbs_sync_state_t;

    hbs_sync_state_t st;
    hbs_sync_state_t next_st;

    always_comb
    begin
        next_st.stage1 = din;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= {RESET_VALUE, RESET_VALUE};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign dout = st.stage2;

endmodule : hbs_sync

// ### tb/hbs_host_port_sva.sv
// checker on the host port pins: cycle timing, interrupt delay, handshakes, timer
// assumes two-flop input synchronisers in the block that reset to the idle levels
`timescale 1ns/10ps
module hbs_host_port_sva #(
    parameter int PULSE_CLKS = 4,
    parameter int TIMER_WIDTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic csN,
    input wire logic rw,
    input wire logic [4:0] regSelect,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic transferAckN,
    input wire logic transferAckOe,
    input wire logic portIrqN,
    input wire logic portIrqOe,
    input wire logic hsInAN,
    input wire logic hsInBN,
    input wire logic hsOutAN,
    input wire logic hsOutBN,
    input wire logic pulsedMode,
    input wire logic timerCountIn,
    input wire logic [TIMER_WIDTH-1:0] timerCount,
    input wire logic [7:0] portDataA,
    input wire logic [7:0] portDataB,
    input wire hbs_pkg::hbs_write_t hostWrite
);
    localparam int PMAX = PULSE_CLKS + 1;
    logic [2:0] csS;
    logic [2:0] aS;
    logic [2:0] bS;
    logic [2:0] tS;
    logic [3:0] sinceAck;
    logic hsFall;
    logic tRise;
    // private synchroniser copies, so pin events can be timed from the sync edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            csS <= 3'h7;
            aS <= 3'h7;
            bS <= 3'h7;
            tS <= 3'h0;
            sinceAck <= 4'hf;
        end
        else
        begin
            csS <= {csS[1:0], csN};
            aS <= {aS[1:0], hsInAN};
            bS <= {bS[1:0], hsInBN};
            tS <= {tS[1:0], timerCountIn};
            if ($fell(transferAckN))
                sinceAck <= 4'h1;
            else if (sinceAck != 4'hf)
                sinceAck <= sinceAck + 4'h1;
        end
    end
    assign hsFall = (aS[2] & ~aS[1]) | (bS[2] & ~bS[1]);
    assign tRise = tS[1] & ~tS[2];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence csHeld;
        $past(csN, 4) == 1'b0 && $past(csN, 3) == 1'b0;
    endsequence
    sequence ackAfterTwo;
        ##2 $fell(transferAckN);
    endsequence
    AST_ACK_AFTER_SYNC: assert property ($fell(transferAckN) |-> csHeld)
        else $error("acknowledge without synchronised chip select");
    AST_ACK_NOMINAL: assert property ($fell(csS[1]) && sinceAck >= 4'h8 && !transferAckOe |-> ackAfterTwo)
        else $error("acknowledge not two clocks after select");
    AST_CYCLE_SPACING: assert property ($fell(transferAckN) |-> sinceAck >= 4'h5)
        else $error("new cycle before previous work finished");
    AST_IRQ_DELAY: assert property ($changed(portIrqOe) |-> $past(!csS[1] || hsFall, 3))
        else $error("interrupt changed without a cause three clocks back");
    AST_IRQ_OPEN_DRAIN: assert property (portIrqN == 1'b0)
        else $error("interrupt level not low");
    AST_PULSE_LEN: assert property ($fell(hsOutAN) && pulsedMode |-> ##[1:PMAX] hsOutAN)
        else $error("output handshake pulse too long");
    AST_HS_EARLY_END: assert property ($fell(aS[1]) |-> ##[0:2] hsOutAN)
        else $error("output handshake not ended by input handshake");
    AST_TIMER_STEP: assert property (1'b1 |=> timerCount == $past(timerCount) + TIMER_WIDTH'($past(tRise)))
        else $error("timer count step wrong");
    AST_WRITE_CAPTURE: assert property (hostWrite.strobe |-> $fell(transferAckN)
        && hostWrite.data == $past(dataIn, 4) && hostWrite.regSelect == $past(regSelect, 4))
        else $error("write capture wrong");
endmodule : hbs_host_port_sva

// ### tb/hbs_bus_master.sv
// bus master model: drives select, direction, register select and write data
// assumes a pull-up on the released acknowledge line
`timescale 1ns/10ps
module hbs_bus_master (
    input wire logic clk,
    input wire logic transferAckN,
    input wire logic transferAckOe,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    output logic csN,
    output logic rw,
    output logic [4:0] regSelect,
    output logic [7:0] dataIn
);
    logic ackPin;
    // set by the bench to reselect one clock after a release, before the last cycle has wound down
    logic quick = 1'b0;
    assign ackPin = transferAckOe ? transferAckN : 1'b1;
    initial
    begin
        csN = 1'b1;
        rw = 1'b1;
        regSelect = 5'h00;
        dataIn = 8'h00;
    end
    task automatic access(input logic isRead, input logic [4:0] sel, input logic [7:0] wdata,
        input int slow, output logic [7:0] rdata);
        int n;
        logic seenHigh;
        n = 0;
        seenHigh = 1'b0;
        csN <= 1'b0;
        rw <= isRead;
        regSelect <= sel;
        dataIn <= wdata;
        // an acknowledge still low from the previous cycle must rise before a low counts again
        do
        begin
            @(posedge clk);
            n++;
            if (ackPin === 1'b1)
            begin
                seenHigh = 1'b1;
            end
        end
        while (!(seenHigh && ackPin === 1'b0) && n < 40);
        rdata = dataOe ? dataOut : ~dataIn;
        repeat (slow) @(posedge clk);
        csN <= 1'b1;
        // released data lines must not look like the last value
        dataIn <= ~dataIn;
        if (quick)
        begin
            @(posedge clk);
        end
        else
        begin
            do
            begin
                @(posedge clk);
                n++;
            end
            while (ackPin !== 1'b1 && n < 80);
        end
    endtask : access
endmodule : hbs_bus_master

// ### tb/hbs_host_port_tb.sv
// self-checking bench for the host port timing block
// assumes the master model and checker from tb/; inputs change on rising edges
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        num_checks++; \
        if ((a) !== (b)) \
        begin \
            err_count++; \
            $display("wrong value at %0t: got %h want %h", $time, (a), (b)); \
        end \
    end
module hbs_host_port_tb;
    localparam int PULSE = 16;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsInAN = 1'b1;
    logic hsInBN = 1'b1;
    logic pulsedMode = 1'b0;
    logic timerCountIn = 1'b0;
    logic csN, rw, transferAckN, transferAckOe, dataOe, portIrqN, portIrqOe, hsOutAN, hsOutBN;
    logic [4:0] regSelect;
    logic [7:0] dataIn, dataOut, portDataA, portDataB, a, b, rexp;
    logic [15:0] timerCount;
    hbs_pkg::hbs_write_t hostWrite, wexp;
    hbs_pkg::hbs_write_t expWr[$];
    logic [7:0] expRd[$];
    logic prevAckN = 1'b1;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h8def;
    int rises = 0;
    always #2.5 clk = ~clk;
    hbs_host_port #(.PULSE_CLKS(PULSE), .TIMER_WIDTH(16)) dut (.clk(clk), .sys_rst(sys_rst), .csN(csN),
        .rw(rw), .regSelect(regSelect), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .transferAckN(transferAckN), .transferAckOe(transferAckOe), .portIrqN(portIrqN),
        .portIrqOe(portIrqOe), .hsInAN(hsInAN), .hsInBN(hsInBN), .hsOutAN(hsOutAN), .hsOutBN(hsOutBN),
        .pulsedMode(pulsedMode), .timerCountIn(timerCountIn), .timerCount(timerCount),
        .portDataA(portDataA), .portDataB(portDataB), .hostWrite(hostWrite));
    hbs_bus_master master (.clk(clk), .transferAckN(transferAckN), .transferAckOe(transferAckOe),
        .dataOut(dataOut), .dataOe(dataOe), .csN(csN), .rw(rw), .regSelect(regSelect), .dataIn(dataIn));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic wr(input logic [4:0] sel, input logic [7:0] d);
        logic [7:0] r;
        expWr.push_back({1'b1, sel, d});
        master.access(1'b0, sel, d, 0, r);
    endtask : wr
    task automatic rd(input logic [4:0] sel, input logic [7:0] e, input int slow);
        logic [7:0] r;
        expRd.push_back(e);
        master.access(1'b1, sel, 8'($random(seed)), slow, r);
    endtask : rd
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk)
    begin
        prevAckN <= transferAckN;
        if (hostWrite.strobe === 1'b1)
        begin
            wexp = expWr.pop_front();
            `CHK(hostWrite, wexp)
        end
        if (transferAckN === 1'b0 && prevAckN === 1'b1 && dataOe === 1'b1)
        begin
            rexp = expRd.pop_front();
            `CHK(dataOut, rexp)
        end
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        #1;
        `CHK({dataOe, transferAckN, transferAckOe, portIrqN, portIrqOe, hsOutAN, hsOutBN}, 7'h23)
        `CHK({timerCount, portDataA, portDataB, hostWrite}, 46'h0)
        a = 8'($random(seed));
        b = 8'($random(seed));
        tick(1);
        wr(hbs_pkg::REG_DATA_A, a);
        wr(hbs_pkg::REG_DATA_B, b);
        wr(5'h1f, 8'h5a);
        rd(hbs_pkg::REG_DATA_A, a, 0);
        rd(hbs_pkg::REG_DATA_B, b, 5);
        rd(5'h10, 8'h00, 0);
        `CHK({portDataA, portDataB, hsOutAN, hsOutBN}, {a, b, 2'h0})
        hsInAN <= 1'b0;
        tick(4);
        #1;
        `CHK({hsOutAN, portIrqOe}, 2'h2)
        tick(1);
        hsInAN <= 1'b1;
        rd(hbs_pkg::REG_STATUS, 8'h01, 0);
        wr(hbs_pkg::REG_ENABLE, 8'h03);
        #1;
        `CHK(portIrqOe, 1'b1)
        tick(1);
        wr(hbs_pkg::REG_STATUS, 8'h01);
        #1;
        `CHK(portIrqOe, 1'b0)
        tick(1);
        hsInBN <= 1'b0;
        tick(4);
        #1;
        `CHK(portIrqOe, 1'b0)
        tick(1);
        #1;
        `CHK(portIrqOe, 1'b1)
        tick(1);
        hsInBN <= 1'b1;
        rd(hbs_pkg::REG_STATUS, 8'h02, 0);
        wr(hbs_pkg::REG_STATUS, 8'h02);
        // handshake lands on the same edge as the access starts
        hsInBN <= 1'b0;
        rd(hbs_pkg::REG_ENABLE, 8'h03, 0);
        #1;
        `CHK(portIrqOe, 1'b1)
        tick(1);
        hsInBN <= 1'b1;
        wr(hbs_pkg::REG_STATUS, 8'h02);
        pulsedMode <= 1'b1;
        wr(hbs_pkg::REG_DATA_A, 8'h3c);
        #1;
        `CHK(hsOutAN, 1'b0)
        tick(1);
        hsInAN <= 1'b0;
        tick(4);
        #1;
        `CHK(hsOutAN, 1'b1)
        tick(1);
        hsInAN <= 1'b1;
        wr(hbs_pkg::REG_DATA_A, 8'hc3);
        tick(PULSE + 2);
        #1;
        `CHK(hsOutAN, 1'b1)
        tick(1);
        // reselect one clock after release: the next cycle lands while the last is still finishing
        master.quick = 1'b1;
        rd(hbs_pkg::REG_DATA_B, b, 0);
        master.quick = 1'b0;
        wr(hbs_pkg::REG_DATA_B, a);
        rd(hbs_pkg::REG_DATA_B, a, 0);
        tick(1);
        // periods of four clocks or more, well below the clock rate
        for (int i = 0; i < 64; i++)
        begin
            rises += timerCountIn ? 0 : 1;
            timerCountIn <= ~timerCountIn;
            tick(2 + ($random(seed) & 1));
        end
        tick(4);
        #1;
        `CHK(timerCount, 16'(rises))
        `CHK(expRd.size() + expWr.size(), 0)
        tally_and_finish();
    end
endmodule : hbs_host_port_tb
bind hbs_host_port hbs_host_port_sva #(.PULSE_CLKS(PULSE_CLKS), .TIMER_WIDTH(TIMER_WIDTH)) chk (.clk(clk),
    .sys_rst(sys_rst), .csN(csN), .rw(rw), .regSelect(regSelect), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .transferAckN(transferAckN), .transferAckOe(transferAckOe), .portIrqN(portIrqN),
    .portIrqOe(portIrqOe), .hsInAN(hsInAN), .hsInBN(hsInBN), .hsOutAN(hsOutAN), .hsOutBN(hsOutBN),
    .pulsedMode(pulsedMode), .timerCountIn(timerCountIn), .timerCount(timerCount),
    .portDataA(portDataA), .portDataB(portDataB), .hostWrite(hostWrite));
